//--- rtl/cee_exception_entry.sv
// Exception-entry unit: soft reset, external interrupt, TLB miss entry.
// Assumes pipeline status, condition field zero and buffer misses arrive
// synchronous to clk from the rest of the core.
`timescale 1ns/10ps
// Functional notes
// (RULE_01) Soft reset keeps all state except clearing the icache enable; the code also forces the sequencer to CEE_RUN and clears complete_block.
// (RULE_02) After soft reset, fetch restarts at vector offset 0x0100.
// (RULE_03) On external interrupt the next instruction completes, with exceptions.
// (RULE_04) Later instructions are blocked; outstanding stores still drain.
// (RULE_05) The interrupt source negates its request on handler acknowledge.
// (RULE_06) Saved bits 0-3 from condition field zero, 4-11 clear, 16-31 from msw.
// (RULE_07) Saved bit 12 is supervisor or user key by access privilege.
// (RULE_08) Saved bit 13 is 0 for data miss, 1 for instruction miss.
// (RULE_09) Saved bit 14 reports the LRU replacement set.
// (RULE_10) Saved bit 15 is 0 for load miss, 1 for store or changed-clear.
// (RULE_11) Instruction buffer miss sets bit 13 and machine state bit 14.
// (RULE_12) Data load miss clears bit 13 and sets machine state bit 14.
// (RULE_13) Store miss or changed-clear hit clears bit 13, sets msw bit 14.
// (RULE_14) Instruction miss is reported only once the pipeline is empty.
// (RULE_15) Saved status is captured in the cycle the exception is taken.
module cee_exception_entry (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              soft_reset_input,
	input  wire logic              ext_int_n,
	input  wire logic              ext_int_enable,
	input  wire logic [3:0]        condition_field_zero,
	input  wire logic [31:0]       msw_in,
	input  wire cee_pkg::cee_miss_t miss,
	input  wire logic              instr_complete,
	input  wire logic              stores_pending,
	input  wire logic              pipe_empty,
	input  wire logic              cfg_we,
	input  wire logic [31:0]       cfg_wdata,
	input  wire logic              ss_we,
	input  wire logic [31:0]       ss_wdata,
	output logic [31:0]            impl_config_reg0,
	output logic [31:0]            saved_status_word,
	output logic [31:0]            msw_out,
	output logic                   msw_load,
	output cee_pkg::cee_redirect_t redirect,
	output logic                   complete_block
);
	// ==========================================================
	// Sequencer.
	cee_pkg::cee_state_t state;
	cee_pkg::cee_state_t next_state;
	logic [31:0]         next_cfg;
	logic [31:0]         next_ss;
	logic [31:0]         next_msw;
	logic                next_msw_load;
	cee_pkg::cee_redirect_t next_redirect;
	logic                next_block;
	logic                take_data_xlate_buffer;
	logic [30:0]         cfg_rest;
	logic                int_req;
	logic [31:0]         miss_ss;
	logic                icache_en;

	assign int_req   = !ext_int_n && ext_int_enable;
	assign take_data_xlate_buffer = miss.dmiss || (miss.dstore && miss.dchg_clr);

	always_comb begin
		miss_ss = msw_in & cee_pkg::SS_MSW_KEEP_MASK; // RULE_06
		miss_ss[31-cee_pkg::SS_CR0_LO -: 4] = condition_field_zero; // RULE_06
		miss_ss[31-cee_pkg::SS_KEY_BIT] =
			miss.supv ? miss.key_s : miss.key_u; // RULE_07
		miss_ss[31-cee_pkg::SS_ITYPE_BIT] = !take_data_xlate_buffer; // RULE_08
		miss_ss[31-cee_pkg::SS_WAY_BIT] = miss.way; // RULE_09
		miss_ss[31-cee_pkg::SS_STORE_BIT] =
			take_data_xlate_buffer && miss.dstore; // RULE_10
	end

	always_comb begin
		next_state    = state;
		next_cfg      = impl_config_reg0;
		next_ss       = saved_status_word;
		next_msw      = msw_out;
		next_msw_load = 1'b0;
		next_redirect = '0;
		next_block    = complete_block;
		if (cfg_we) begin
			next_cfg = cfg_wdata;
		end
		if (ss_we) begin
			next_ss = ss_wdata;
		end
		if (soft_reset_input) begin
			next_cfg[31-cee_pkg::ICACHE_EN_BIT] = 1'b0; // RULE_01
			next_redirect = '{valid: 1'b1,
				addr: cee_pkg::RESET_VECTOR}; // RULE_02
			next_state = cee_pkg::CEE_RUN;
			next_block = 1'b0;
		end else begin
			unique case (state)
				cee_pkg::CEE_RUN: begin
					if (take_data_xlate_buffer) begin
						next_ss  = miss_ss; // RULE_15
						next_msw = msw_in;
						next_msw[31-cee_pkg::MSW_TGPR_BIT] = 1'b1; // RULE_12 RULE_13
						next_msw_load = 1'b1;
						next_redirect = '{valid: 1'b1, addr: miss.dstore ?
							cee_pkg::DATA_XLATE_BUFFER_ST_VECTOR : cee_pkg::DATA_XLATE_BUFFER_LD_VECTOR};
					end else if (miss.imiss) begin
						next_state = cee_pkg::CEE_INSTR_XLATE_BUFFER_WT; // RULE_14
					end else if (int_req) begin
						next_state = cee_pkg::CEE_INT_NEXT; // RULE_03
					end
				end
				cee_pkg::CEE_INT_NEXT: begin
					if (instr_complete) begin
						next_block = 1'b1; // RULE_04
						next_state = cee_pkg::CEE_INT_DRN;
					end
				end
				cee_pkg::CEE_INT_DRN: begin
					if (!stores_pending) begin // RULE_04
						next_msw_load = 1'b1;
						next_msw      = msw_in;
						next_redirect = '{valid: 1'b1,
							addr: cee_pkg::EXT_INT_VECTOR};
						next_block = 1'b0;
						next_state = cee_pkg::CEE_RUN;
					end
				end
				cee_pkg::CEE_INSTR_XLATE_BUFFER_WT: begin
					if (pipe_empty) begin // RULE_14
						next_state = cee_pkg::CEE_TAKE;
					end
				end
				cee_pkg::CEE_TAKE: begin
					next_ss  = miss_ss; // RULE_11 RULE_15
					next_ss[31-cee_pkg::SS_ITYPE_BIT] = 1'b1; // RULE_08
					next_ss[31-cee_pkg::SS_STORE_BIT] = 1'b0; // RULE_10
					next_msw = msw_in;
					next_msw[31-cee_pkg::MSW_TGPR_BIT] = 1'b1; // RULE_11
					next_msw_load = 1'b1;
					next_redirect = '{valid: 1'b1,
						addr: cee_pkg::INSTR_XLATE_BUFFER_VECTOR};
					next_block = 1'b0;
					next_state = cee_pkg::CEE_RUN;
				end
				default: begin
					next_state = cee_pkg::CEE_RUN;
				end
			endcase
		end
	end

	// ==========================================================
	// Registers. Soft reset is handled above, never here.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state             <= cee_pkg::CEE_RUN;
			saved_status_word <= cee_pkg::SS_RESET;
			msw_out           <= cee_pkg::MSW_RESET;
			msw_load          <= 1'b0;
			redirect          <= '0;
			complete_block    <= 1'b0;
		end else begin
			state             <= next_state;
			saved_status_word <= next_ss;
			msw_out           <= next_msw;
			msw_load          <= next_msw_load;
			redirect          <= next_redirect;
			complete_block    <= next_block;
		end
	end

	// Configuration word; the icache enable bit kept in its own flop.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rest <= {cee_pkg::CACHE_EN_RESET[31:16],
				cee_pkg::CACHE_EN_RESET[14:0]};
		end else begin
			cfg_rest <= {next_cfg[31:16], next_cfg[14:0]};
		end
	end

	// All bits come straight from flops, so the icache bit never lags.
	assign impl_config_reg0 = {cfg_rest[30:15], icache_en, cfg_rest[14:0]};

	cee_bit_flop #(
		.RESET_VAL (cee_pkg::CACHE_EN_RESET[15])
	) u_icache_en (
		.clk   (clk),
		.rst_n (rst_n),
		.load  (cfg_we || soft_reset_input),
		.d     (next_cfg[31-cee_pkg::ICACHE_EN_BIT]), // RULE_01
		.q     (icache_en)
	);
endmodule : cee_exception_entry

//--- include/cee_pkg.sv
// Package for the core exception-entry unit: constants, states, carriers.
// Assumes bit 0 is the most significant bit of architectural words.
package cee_pkg;

	// ==========================================================
	// Vectors and register layout.
	localparam logic [31:0] RESET_VECTOR     = 32'h0000_0100;
	localparam logic [31:0] CACHE_EN_RESET   = 32'h0000_0000;
	localparam int          ICACHE_EN_BIT    = 16;
	// Saved-status positions in big-endian numbering (0 = msb).
	localparam int          SS_CR0_LO        = 0;
	localparam int          SS_CR0_HI        = 3;
	localparam int          SS_KEY_BIT       = 12;
	localparam int          SS_ITYPE_BIT     = 13;
	localparam int          SS_WAY_BIT       = 14;
	localparam int          SS_STORE_BIT     = 15;
	localparam int          MSW_TGPR_BIT     = 14;
	localparam logic [31:0] SS_MSW_KEEP_MASK = 32'h0000_ffff;
	localparam logic [31:0] SS_RESET         = 32'h0000_0000;
	localparam logic [31:0] MSW_RESET        = 32'h0000_0000;
	localparam logic [31:0] INSTR_XLATE_BUFFER_VECTOR      = 32'h0000_1000;
	localparam logic [31:0] DATA_XLATE_BUFFER_LD_VECTOR   = 32'h0000_1100;
	localparam logic [31:0] DATA_XLATE_BUFFER_ST_VECTOR   = 32'h0000_1200;
	localparam logic [31:0] EXT_INT_VECTOR   = 32'h0000_0500;

	// ==========================================================
	// Sequencer states.
	typedef enum logic [2:0] {
		CEE_RUN      = 3'b000,
		CEE_INT_NEXT = 3'b001,
		CEE_INT_DRN  = 3'b010,
		CEE_INSTR_XLATE_BUFFER_WT  = 3'b011,
		CEE_TAKE     = 3'b100
	} cee_state_t;

	// ==========================================================
	// Translation miss report from the buffers.
	typedef struct packed {
		logic imiss;
		logic dmiss;
		logic dstore;
		logic dchg_clr;
		logic supv;
		logic key_s;
		logic key_u;
		logic way;
	} cee_miss_t;

	// Vector redirect to fetch.
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} cee_redirect_t;

endpackage : cee_pkg

//--- rtl/cee_bit_flop.sv
// One synchronous register bit with load enable.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/10ps
module cee_bit_flop #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic load,
	input  wire logic d,
	output logic      q
);
	logic next_q;

	always_comb begin
		next_q = load ? d : q;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= RESET_VAL;
		end else begin
			q <= next_q;
		end
	end
endmodule : cee_bit_flop

//--- verif/cee_int_src.sv
// Model of the interrupt source: drives the active-low request line.
// Assumes the bench raises and acknowledges on rising clock edges.
`timescale 1ns/10ps
module cee_int_src (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic raise,
	input  wire logic ack,
	output logic      ext_int_n
);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) ext_int_n <= 1'b1;
		else if (ack) ext_int_n <= 1'b1;
		else if (raise) ext_int_n <= 1'b0;
	end
endmodule : cee_int_src

//--- verif/cee_exception_entry_sva.sv
// Checker for the exception-entry unit, watching its ports only.
// Assumes architectural bit n sits at vector bit 31-n.
`timescale 1ns/10ps
module cee_exception_entry_sva (
	input wire logic                   clk,
	input wire logic                   rst_n,
	input wire logic                   soft_reset_input,
	input wire logic [3:0]             condition_field_zero,
	input wire logic [31:0]            msw_in,
	input wire cee_pkg::cee_miss_t     miss,
	input wire logic                   instr_complete,
	input wire logic                   stores_pending,
	input wire logic                   pipe_empty,
	input wire logic [31:0]            impl_config_reg0,
	input wire logic [31:0]            saved_status_word,
	input wire logic [31:0]            msw_out,
	input wire cee_pkg::cee_redirect_t redirect,
	input wire logic                   complete_block
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic [31:0] ss = saved_status_word;
	wire logic [31:0] ra = redirect.addr;
	sequence dtake_s;
		redirect.valid && (ra == 32'h0000_1100 || ra == 32'h0000_1200);
	endsequence
	sequence itake_s;
		redirect.valid && ra == 32'h0000_1000;
	endsequence
	srst_vector_a: assert property (
		soft_reset_input |=> redirect.valid && ra == 32'h0000_0100)
		else $error("soft reset vector wrong");
	srst_icache_a: assert property (
		soft_reset_input |=> !impl_config_reg0[15])
		else $error("icache enable kept on soft reset");
	data_code_a: assert property (
		dtake_s |-> ss[16] == $past(miss.dstore) && !ss[18] && msw_out[17])
		else $error("data miss codes wrong");
	key_way_a: assert property (
		dtake_s |-> ss[17] == $past(miss.way) && ss[19] ==
		$past(miss.supv ? miss.key_s : miss.key_u))
		else $error("key or way wrong");
	field_copy_a: assert property (
		dtake_s |-> ss[31:28] == $past(condition_field_zero) &&
		ss[27:20] == 8'h00 && ss[15:0] == $past(msw_in[15:0]))
		else $error("copied fields wrong");
	instr_miss_a: assert property (
		itake_s |-> ss[18] && msw_out[17] && $past(pipe_empty, 2))
		else $error("instruction miss entry wrong");
	int_next_a: assert property (
		$rose(complete_block) |-> $past(instr_complete))
		else $error("block without completion");
	int_drain_a: assert property (
		complete_block && stores_pending && !soft_reset_input
		|=> !redirect.valid && complete_block)
		else $error("interrupt taken before stores drained");
endmodule : cee_exception_entry_sva
bind cee_exception_entry cee_exception_entry_sva chk_u (.clk, .rst_n,
	.soft_reset_input, .condition_field_zero, .msw_in, .miss,
	.instr_complete, .stores_pending, .pipe_empty, .impl_config_reg0,
	.saved_status_word, .msw_out, .redirect, .complete_block);

//--- verif/testbench.sv
// Self-checking bench for the exception-entry unit.
// Assumes the interrupt source model drives the request line.
`timescale 1ns/10ps
module testbench;
	typedef struct packed {
		logic [7:0]  m;
		logic [3:0]  c;
		logic [31:0] w, ss, a;
	} cee_row_t;
	localparam cee_row_t rows [4] = '{
		'{8'h42, 4'ha, 32'h1234_5678, 32'ha008_5678, 32'h0000_1100},
		'{8'h6d, 4'h5, 32'hffff_0001, 32'h500b_0001, 32'h0000_1200},
		'{8'h3a, 4'hf, 32'h0000_8000, 32'hf001_8000, 32'h0000_1200},
		'{8'h4b, 4'h0, 32'h0000_ffff, 32'h0002_ffff, 32'h0000_1100}};
	logic clk = 0, rst_n = 0, soft_reset_input = 0, ext_int_n, raise = 0;
	logic ack = 0, ext_int_enable = 0, instr_complete = 0, pipe_empty = 0;
	logic stores_pending = 0, cfg_we = 0, ss_we = 0, msw_load, complete_block;
	logic [3:0] condition_field_zero = 0;
	logic [31:0] msw_in = 0, cfg_wdata = 0, ss_wdata = 0, impl_config_reg0;
	logic [31:0] saved_status_word, msw_out;
	cee_pkg::cee_miss_t miss = '0;
	cee_pkg::cee_redirect_t redirect;
	int err_count = 0, tests_run = 0, cycles = 0, r;
	cee_exception_entry dut_u (.clk, .rst_n, .soft_reset_input, .ext_int_n,
		.ext_int_enable, .condition_field_zero, .msw_in, .miss,
		.instr_complete, .stores_pending, .pipe_empty, .cfg_we, .cfg_wdata,
		.ss_we, .ss_wdata, .impl_config_reg0, .saved_status_word, .msw_out,
		.msw_load, .redirect, .complete_block);
	cee_int_src src_u (.clk, .rst_n, .raise, .ack, .ext_int_n);
	always #20 clk = ~clk;
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			end_of_test();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task wait_redir;
		for (int i = 0; i < 8 && redirect.valid !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
	endtask : wait_redir
	task end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1 chk(saved_status_word, 32'h0000_0000);
		chk(impl_config_reg0, 32'h0000_0000);
		for (r = 0; r < 4; r++) begin
			@(posedge clk);
			miss <= rows[r].m;
			condition_field_zero <= rows[r].c;
			msw_in <= rows[r].w;
			@(posedge clk);
			miss <= '0;
			#1 wait_redir();
			chk(saved_status_word, rows[r].ss);
			chk(redirect.addr, rows[r].a);
			chk({31'h0, msw_out[17]}, 32'h0000_0001);
			chk({31'h0, msw_load}, 32'h0000_0001);
		end
		$display("data miss rows done");
		@(posedge clk);
		miss <= 8'h81;
		@(posedge clk);
		miss <= '0;
		repeat (3) @(posedge clk);
		#1 chk({31'h0, redirect.valid}, 32'h0000_0000);
		@(posedge clk);
		pipe_empty <= 1'b1;
		#1 wait_redir();
		chk(redirect.addr, 32'h0000_1000);
		chk({31'h0, saved_status_word[18]}, 32'h0000_0001);
		$display("instruction miss done");
		@(posedge clk);
		ext_int_enable <= 1'b1;
		raise <= 1'b1;
		stores_pending <= 1'b1;
		@(posedge clk);
		raise <= 1'b0;
		@(posedge clk);
		ext_int_enable <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({31'h0, complete_block}, 32'h0000_0000);
		@(posedge clk);
		instr_complete <= 1'b1;
		@(posedge clk);
		instr_complete <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk({31'h0, complete_block}, 32'h0000_0001);
		chk({31'h0, redirect.valid}, 32'h0000_0000);
		@(posedge clk);
		stores_pending <= 1'b0;
		#1 wait_redir();
		chk(redirect.addr, 32'h0000_0500);
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		#1 chk({31'h0, ext_int_n}, 32'h0000_0001);
		$display("interrupt done");
		@(posedge clk);
		cfg_we <= 1'b1;
		cfg_wdata <= 32'hffff_ffff;
		ss_we <= 1'b1;
		ss_wdata <= 32'h5a5a_a5a5;
		@(posedge clk);
		cfg_we <= 1'b0;
		ss_we <= 1'b0;
		soft_reset_input <= 1'b1;
		#1 chk(impl_config_reg0, 32'hffff_ffff);
		@(posedge clk);
		soft_reset_input <= 1'b0;
		#1 chk(redirect.addr, 32'h0000_0100);
		chk(impl_config_reg0, 32'hffff_7fff);
		chk(saved_status_word, 32'h5a5a_a5a5);
		$display("soft reset done");
		end_of_test();
	end
endmodule : testbench
